// *** common/usb_frame_pkg.sv ***
// constants and carrier types for the usb frame number and interrupt enable registers
package usb_frame_pkg;

    // --------------------------------------------------------------
    // register bus
    // --------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W  = 16;

    localparam logic [7:0] FRAME_STATUS_OFFSET     = 8'h10;
    localparam logic [7:0] IRQ_ENABLE_CLEAR_OFFSET = 8'h14;
    localparam logic [7:0] IRQ_ENABLE_SET_OFFSET   = 8'h18;
    localparam logic [7:0] IRQ_FLAG_OFFSET         = 8'h1c;

    localparam logic [15:0] REG_RESET_VALUE = 16'h0000;
    localparam logic [31:0] READ_IDLE_VALUE = 32'h0000_0000;

    // --------------------------------------------------------------
    // frame status fields
    // --------------------------------------------------------------
    localparam int FRAME_ERROR_BIT = 15;
    localparam int FRAME_RSVD_BIT  = 14;
    localparam int FRAME_IDX_LSB   = 3;
    localparam int FRAME_IDX_W     = 11;
    localparam int MICRO_IDX_LSB   = 0;
    localparam int MICRO_IDX_W     = 3;

    localparam logic [10:0] FRAME_IDX_RESET = 11'h000;
    localparam logic [2:0]  MICRO_IDX_RESET = 3'h0;

    // --------------------------------------------------------------
    // interrupt source positions
    // --------------------------------------------------------------
    localparam int IRQ_SUSPEND_BIT       = 0;
    localparam int IRQ_SOF_BIT           = 2;
    localparam int IRQ_END_OF_RESET_BIT  = 3;
    localparam int IRQ_WAKE_BIT          = 4;
    localparam int IRQ_END_OF_RESUME_BIT = 5;
    localparam int IRQ_UP_RESUME_BIT     = 6;
    localparam int IRQ_BUF_ERROR_BIT     = 7;
    localparam int IRQ_LP_NOT_YET_BIT    = 8;
    localparam int IRQ_LP_SUSPEND_BIT    = 9;

    // bits 15:10 and 1 are reserved
    localparam logic [15:0] IRQ_IMPL_MASK = 16'h03fd;

    // --------------------------------------------------------------
    // carriers
    // --------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic        check_ok;
        logic [10:0] number;
    } sof_token_type;

    typedef struct packed {
        logic       valid;
        logic       check_ok;
        logic [2:0] number;
    } msof_token_type;

    typedef struct packed {
        logic link_power_suspend;
        logic link_power_not_yet;
        logic buffer_access_error;
        logic upstream_resume;
        logic end_of_resume;
        logic wake;
        logic end_of_bus_reset;
        logic suspend;
    } usb_event_type;

endpackage

// *** rtl/frame_tracker.sv ***
// frame and micro-frame number capture with token check error indication
`timescale 1ns/1ps
module frame_tracker (
    input  wire logic                           clk,
    input  wire logic                           rst_n,
    input  wire logic                           usb_bus_reset,
    input  wire usb_frame_pkg::sof_token_type   sof_token,
    input  wire usb_frame_pkg::msof_token_type  msof_token,
    output logic [10:0]                         frame_index,
    output logic [2:0]                          micro_frame_index,
    output logic                                frame_check_error,
    output logic                                frame_token_seen
);

    // same cycle as the flag bank samples it, so error and flag move together
    assign frame_token_seen = sof_token.valid | msof_token.valid;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_check_error <= 1'b0;
        end else if (usb_bus_reset) begin
            frame_check_error <= 1'b0;
        end else if (frame_token_seen) begin
            // latest token decides; a good token drops a stale error
            frame_check_error <= sof_token.valid ? ~sof_token.check_ok
                                                 : ~msof_token.check_ok;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_index <= usb_frame_pkg::FRAME_IDX_RESET;
        end else if (usb_bus_reset) begin
            frame_index <= usb_frame_pkg::FRAME_IDX_RESET;
        end else if (sof_token.valid) begin
            frame_index <= sof_token.number;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            micro_frame_index <= usb_frame_pkg::MICRO_IDX_RESET;
        end else if (usb_bus_reset || sof_token.valid) begin
            micro_frame_index <= usb_frame_pkg::MICRO_IDX_RESET;
        end else if (msof_token.valid) begin
            micro_frame_index <= msof_token.number;
        end
    end

endmodule

// *** rtl/irq_flag_bank.sv ***
// sticky interrupt flags, cleared by writing ones, set wins over clear
`timescale 1ns/1ps
module irq_flag_bank (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [15:0] set_pulse,
    input  wire logic [15:0] clear_mask,
    output logic [15:0]      flags
);

    logic [15:0] next_flags;

    always_comb begin
        next_flags = ((flags & ~clear_mask) | set_pulse) & usb_frame_pkg::IRQ_IMPL_MASK;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags <= usb_frame_pkg::REG_RESET_VALUE;
        end else begin
            flags <= next_flags;
        end
    end

endmodule

// *** rtl/usb_frame_irq_regs.sv ***
// register bank: frame number status, interrupt enable set/clear, flags and irq line
//
// How it works
// - a usb bus reset clears the frame check error bit 15 of the frame status.
// - a sof token, or an msof token with no sof in the same cycle, whose check fails sets the frame check error bit.
// - the frame check error bit changes on the same edge as the start-of-frame flag.
// - the 11-bit frame index in bits 13:3 takes the number of every sof, good or corrupt.
// - usb bus reset clears frame and micro-frame index; every sof clears bits 2:0.
// - the micro-frame index takes the number of every msof, good or corrupt, unless a sof comes in the same cycle.
// - bit 14 of the frame status always reads zero.
// - enable-clear and enable-set are two windows on one shared enable vector.
// - writing a one to enable-clear at 0x14 drops that enable bit.
// - zeros written to either enable register leave the enables untouched.
// - writing a one to enable-set at 0x18 raises that enable bit.
// - an enabled source whose flag becomes set requests an interrupt.
// - enable positions: 9 lp suspend, 8 lp not yet, 7 buffer error, 6 up resume,
//       5 end of resume, 4 wake, 3 end of reset, 2 start of frame, 0 suspend.
// - reserved enable bits 15:10 and 1 read as zero and cannot be set.
// - each start of frame, nominally once per 1 ms, sets the sof flag with the index.
`timescale 1ns/1ps
module usb_frame_irq_regs (
    input  wire logic                           clk,
    input  wire logic                           rst_n,
    input  wire logic [7:0]                     reg_addr,
    input  wire logic [31:0]                    reg_wdata,
    input  wire logic                           reg_write,
    input  wire logic                           reg_read,
    output logic [31:0]                         reg_rdata,
    input  wire logic                           usb_bus_reset,
    input  wire usb_frame_pkg::sof_token_type   sof_token,
    input  wire usb_frame_pkg::msof_token_type  msof_token,
    input  wire usb_frame_pkg::usb_event_type   usb_events,
    output logic                                irq
);

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------

    function automatic logic hits(
        input logic       strobe,
        input logic [7:0] addr,
        input logic [7:0] offset
    );
        hits = strobe && (addr == offset);
    endfunction

    // low half carries the register, upper half reads as zero
    function automatic logic [31:0] widen(
        input logic [15:0] value
    );
        widen = {16'h0000, value};
    endfunction

    // place each external event at its documented source position
    function automatic logic [15:0] event_vector(
        input usb_frame_pkg::usb_event_type ev,
        input logic                         sof_seen
    );
        logic [15:0] v;
        v = usb_frame_pkg::REG_RESET_VALUE;
        v[usb_frame_pkg::IRQ_SUSPEND_BIT]       = ev.suspend;
        v[usb_frame_pkg::IRQ_SOF_BIT]           = sof_seen;
        v[usb_frame_pkg::IRQ_END_OF_RESET_BIT]  = ev.end_of_bus_reset;
        v[usb_frame_pkg::IRQ_WAKE_BIT]          = ev.wake;
        v[usb_frame_pkg::IRQ_END_OF_RESUME_BIT] = ev.end_of_resume;
        v[usb_frame_pkg::IRQ_UP_RESUME_BIT]     = ev.upstream_resume;
        v[usb_frame_pkg::IRQ_BUF_ERROR_BIT]     = ev.buffer_access_error;
        v[usb_frame_pkg::IRQ_LP_NOT_YET_BIT]    = ev.link_power_not_yet;
        v[usb_frame_pkg::IRQ_LP_SUSPEND_BIT]    = ev.link_power_suspend;
        event_vector = v;
    endfunction

    // --------------------------------------------------------------
    // address decode
    // --------------------------------------------------------------

    logic write_enable_clear;
    logic write_enable_set;
    logic write_flag;
    logic [15:0] write_bits;

    assign write_bits         = reg_wdata[15:0];
    assign write_enable_clear = hits(reg_write, reg_addr,
                                     usb_frame_pkg::IRQ_ENABLE_CLEAR_OFFSET);
    assign write_enable_set   = hits(reg_write, reg_addr,
                                     usb_frame_pkg::IRQ_ENABLE_SET_OFFSET);
    assign write_flag         = hits(reg_write, reg_addr,
                                     usb_frame_pkg::IRQ_FLAG_OFFSET);

    // --------------------------------------------------------------
    // frame number tracking
    // --------------------------------------------------------------

    logic [10:0] frame_index;
    logic [2:0]  micro_frame_index;
    logic        frame_check_error;
    logic        frame_token_seen;

    frame_tracker frame_tracker_inst (
        .clk               (clk),
        .rst_n             (rst_n),
        .usb_bus_reset     (usb_bus_reset),
        .sof_token         (sof_token),
        .msof_token        (msof_token),
        .frame_index       (frame_index),
        .micro_frame_index (micro_frame_index),
        .frame_check_error (frame_check_error),
        .frame_token_seen  (frame_token_seen)
    );

    logic [15:0] frame_status;

    always_comb begin
        frame_status = usb_frame_pkg::REG_RESET_VALUE;
        frame_status[usb_frame_pkg::FRAME_ERROR_BIT] = frame_check_error;
        frame_status[usb_frame_pkg::FRAME_RSVD_BIT]  = 1'b0;
        frame_status[usb_frame_pkg::FRAME_IDX_LSB +: usb_frame_pkg::FRAME_IDX_W] =
            frame_index;
        frame_status[usb_frame_pkg::MICRO_IDX_LSB +: usb_frame_pkg::MICRO_IDX_W] =
            micro_frame_index;
    end

    // --------------------------------------------------------------
    // interrupt flags
    // --------------------------------------------------------------

    logic [15:0] flag_set;
    logic [15:0] flag_clear;
    logic [15:0] irq_flags;

    // sof flag shares the token edge with the error bit
    assign flag_set   = event_vector(usb_events, frame_token_seen);
    assign flag_clear = write_flag ? write_bits : usb_frame_pkg::REG_RESET_VALUE;

    irq_flag_bank irq_flag_bank_inst (
        .clk        (clk),
        .rst_n      (rst_n),
        .set_pulse  (flag_set),
        .clear_mask (flag_clear),
        .flags      (irq_flags)
    );

    // --------------------------------------------------------------
    // interrupt enables
    // --------------------------------------------------------------

    // one vector behind both addresses, so no read-modify-write is needed
    logic [15:0] irq_enable;
    logic [15:0] next_irq_enable;

    always_comb begin
        next_irq_enable = irq_enable;
        if (write_enable_clear) begin
            next_irq_enable = irq_enable & ~write_bits;
        end else if (write_enable_set) begin
            next_irq_enable = irq_enable | write_bits;
        end
        next_irq_enable = next_irq_enable & usb_frame_pkg::IRQ_IMPL_MASK;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_enable <= usb_frame_pkg::REG_RESET_VALUE;
        end else begin
            irq_enable <= next_irq_enable;
        end
    end

    // --------------------------------------------------------------
    // interrupt line
    // --------------------------------------------------------------

    // level output: drops as soon as the flag is cleared or the enable dropped
    assign irq = |(irq_flags & irq_enable);

    // --------------------------------------------------------------
    // read path
    // --------------------------------------------------------------

    logic [31:0] read_value;

    always_comb begin
        case (reg_addr)
            usb_frame_pkg::FRAME_STATUS_OFFSET: begin
                read_value = widen(frame_status);
            end
            usb_frame_pkg::IRQ_ENABLE_CLEAR_OFFSET: begin
                read_value = widen(irq_enable);
            end
            usb_frame_pkg::IRQ_ENABLE_SET_OFFSET: begin
                read_value = widen(irq_enable);
            end
            usb_frame_pkg::IRQ_FLAG_OFFSET: begin
                read_value = widen(irq_flags);
            end
            default: begin
                read_value = usb_frame_pkg::READ_IDLE_VALUE;
            end
        endcase
    end

    // data stands only in the cycle after the read strobe; zero otherwise
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= usb_frame_pkg::READ_IDLE_VALUE;
        end else if (reg_read) begin
            reg_rdata <= read_value;
        end else begin
            reg_rdata <= usb_frame_pkg::READ_IDLE_VALUE;
        end
    end

endmodule

// *** test/usb_frame_irq_checker.sv ***
// assertion checker for the frame status and interrupt enable register bank
`timescale 1ns/1ps
module usb_frame_irq_checker (
    input wire logic                          clk,
    input wire logic                          rst_n,
    input wire logic [7:0]                    reg_addr,
    input wire logic [31:0]                   reg_wdata,
    input wire logic                          reg_write,
    input wire logic                          reg_read,
    input wire logic [31:0]                   reg_rdata,
    input wire logic                          usb_bus_reset,
    input wire usb_frame_pkg::sof_token_type  sof_token,
    input wire usb_frame_pkg::msof_token_type msof_token,
    input wire usb_frame_pkg::usb_event_type  usb_events,
    input wire logic                          irq
);
    // ----------------------------------------------------------
    // properties
    // ----------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_status_rsvd: assert property (
        $past(reg_read && reg_addr == 8'h10) |-> reg_rdata[31:16] == 16'h0000 && !reg_rdata[14])
        else $error("reserved status bits not zero");
    chk_sof_error: assert property (
        sof_token.valid && !sof_token.check_ok && !usb_bus_reset ##1 reg_read && reg_addr == 8'h10
        |=> reg_rdata[15]) else $error("bad sof did not set error bit");
    chk_frame_load: assert property (
        sof_token.valid && !usb_bus_reset ##1 reg_read && reg_addr == 8'h10
        |=> reg_rdata[13:0] == {$past(sof_token.number, 2), 3'h0})
        else $error("frame index not loaded by sof");
    chk_micro_load: assert property (
        msof_token.valid && !sof_token.valid && !usb_bus_reset ##1 reg_read && reg_addr == 8'h10
        |=> reg_rdata[2:0] == $past(msof_token.number, 2)
        && reg_rdata[15] == !$past(msof_token.check_ok, 2))
        else $error("micro index not loaded by msof");
    chk_bus_reset: assert property (
        usb_bus_reset && !sof_token.valid && !msof_token.valid ##1 reg_read && reg_addr == 8'h10
        |=> reg_rdata[15:0] == 16'h0000) else $error("bus reset left frame status");
    chk_clear_shared: assert property (
        reg_write && reg_addr == 8'h14 ##1 reg_read && reg_addr == 8'h18
        |=> (reg_rdata[15:0] & $past(reg_wdata[15:0], 2)) == 16'h0000)
        else $error("enable clear not seen through set view");
    chk_set_shared: assert property (
        reg_write && reg_addr == 8'h18 ##1 reg_read && reg_addr == 8'h14
        |=> (reg_rdata[15:0] & $past(reg_wdata[15:0], 2) & usb_frame_pkg::IRQ_IMPL_MASK)
        == ($past(reg_wdata[15:0], 2) & usb_frame_pkg::IRQ_IMPL_MASK))
        else $error("enable set not seen through clear view");
    chk_enable_rsvd: assert property (
        $past(reg_read && (reg_addr == 8'h14 || reg_addr == 8'h18 || reg_addr == 8'h1c))
        |-> (reg_rdata & 32'hffff_fc02) == 32'h0000_0000) else $error("reserved enable bit set");
    chk_irq_masked: assert property (
        $past(reg_read && reg_addr == 8'h14) && reg_rdata[15:0] == 16'h0000 |-> !irq)
        else $error("irq high with no enable");
    chk_irq_raise: assert property (
        $past(reg_read && reg_addr == 8'h14 && sof_token.valid) && reg_rdata[2] |-> irq)
        else $error("enabled sof flag gave no irq");
endmodule

bind usb_frame_irq_regs usb_frame_irq_checker usb_frame_irq_checker_inst (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .usb_bus_reset(usb_bus_reset), .sof_token(sof_token), .msof_token(msof_token),
    .usb_events(usb_events), .irq(irq));

// *** test/usb_engine_model.sv ***
// behavioural usb protocol engine feeding tokens, events and bus reset
`timescale 1ns/1ps
module usb_engine_model (
    input  wire logic                     clk,
    output usb_frame_pkg::sof_token_type  sof_token,
    output usb_frame_pkg::msof_token_type msof_token,
    output usb_frame_pkg::usb_event_type  usb_events,
    output logic                          usb_bus_reset
);
    initial begin
        sof_token = '0;
        msof_token = '0;
        usb_events = '0;
        usb_bus_reset = 1'b0;
    end
    // released numbers flip so a stale value never passes as fresh
    task automatic sof(input logic ok, input logic [10:0] num);
        sof_token <= {1'b1, ok, num};
        @(posedge clk);
        sof_token <= {1'b0, ~ok, ~num};
    endtask
    task automatic msof(input logic ok, input logic [2:0] num);
        msof_token <= {1'b1, ok, num};
        @(posedge clk);
        msof_token <= {1'b0, ~ok, ~num};
    endtask
    task automatic pulse(input int k);
        usb_events <= usb_frame_pkg::usb_event_type'(8'h01 << k);
        @(posedge clk);
        usb_events <= '0;
    endtask
    task automatic bus_reset();
        usb_bus_reset <= 1'b1;
        @(posedge clk);
        usb_bus_reset <= 1'b0;
    endtask
endmodule

// *** test/tb_usb_frame_irq_regs.sv ***
// self-checking bench for the frame status and interrupt enable register bank
`timescale 1ns/1ps
module tb_usb_frame_irq_regs;
    logic                          clk;
    logic                          rst_n;
    logic [7:0]                    reg_addr;
    logic [31:0]                   reg_wdata;
    logic                          reg_write;
    logic                          reg_read;
    logic [31:0]                   reg_rdata;
    logic                          usb_bus_reset;
    usb_frame_pkg::sof_token_type  sof_token;
    usb_frame_pkg::msof_token_type msof_token;
    usb_frame_pkg::usb_event_type  usb_events;
    logic                          irq;
    int                            fails;
    int                            compares;
    int                            cycles;
    logic [15:0]                   pos;

    usb_frame_irq_regs usb_frame_irq_regs_inst (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .usb_bus_reset(usb_bus_reset), .sof_token(sof_token),
        .msof_token(msof_token), .usb_events(usb_events), .irq(irq));
    usb_engine_model usb_engine_model_inst (.clk(clk), .sof_token(sof_token),
        .msof_token(msof_token), .usb_events(usb_events), .usb_bus_reset(usb_bus_reset));

    // ----------------------------------------------------------
    // bus tasks
    // ----------------------------------------------------------
    task automatic final_report();
        if (fails == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic irq_is(input logic e);
        check({31'h0000_0000, irq}, {31'h0000_0000, e});
    endtask
    // strobe stays up so a following access may come with no gap
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_write <= 1'b1;
        reg_read <= 1'b0;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
    endtask
    task automatic idle();
        reg_write <= 1'b0;
        reg_read <= 1'b0;
        @(posedge clk);
    endtask
    // read data is looked at in the one cycle it stands
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        reg_read <= 1'b1;
        reg_write <= 1'b0;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        @(posedge clk);
        check(reg_rdata, exp);
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails++;
            final_report();
        end
    end

    initial begin
        rst_n = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        fails = 0;
        compares = 0;
        cycles = 0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int a = 16; a <= 32; a += 4) rd(a[7:0], '0);
        wr(8'h20, 32'h0000_ffff);
        wr(8'h18, 32'h0000_ffff);
        rd(8'h14, 32'h0000_03fd);
        wr(8'h14, 32'h0000_0000);
        wr(8'h18, 32'h0000_0000);
        rd(8'h18, 32'h0000_03fd);
        for (int i = 0; i < 16; i++) begin
            pos = 16'h0001 << i;
            wr(8'h14, {16'h0000, pos});
            rd(8'h18, {16'h0000, 16'h03fd & ~pos});
            wr(8'h18, {16'h0000, pos});
            rd(8'h14, 32'h0000_03fd);
        end
        rd(8'h20, '0);
        wr(8'h14, 32'h0000_ffff);
        wr(8'h1c, 32'h0000_ffff);
        idle();
        usb_engine_model_inst.sof(1'b0, 11'h123);
        rd(8'h10, 32'h0000_8918);
        rd(8'h1c, 32'h0000_0004);
        usb_engine_model_inst.msof(1'b1, 3'h5);
        rd(8'h10, 32'h0000_091d);
        usb_engine_model_inst.msof(1'b0, 3'h2);
        rd(8'h10, 32'h0000_891a);
        wr(8'h10, 32'h0000_ffff);
        rd(8'h10, 32'h0000_891a);
        usb_engine_model_inst.sof(1'b1, 11'h7ff);
        rd(8'h10, 32'h0000_3ff8);
        usb_engine_model_inst.msof(1'b0, 3'h7);
        rd(8'h10, 32'h0000_bfff);
        usb_engine_model_inst.bus_reset();
        rd(8'h10, '0);
        wr(8'h1c, 32'h0000_ffff);
        idle();
        for (int k = 0; k < 8; k++) begin
            pos = 16'h0001 << ((k == 0) ? 0 : k + 2);
            usb_engine_model_inst.pulse(k);
            rd(8'h1c, {16'h0000, pos});
            irq_is(1'b0);
            wr(8'h18, {16'h0000, pos});
            idle();
            irq_is(1'b1);
            wr(8'h1c, {16'h0000, pos});
            idle();
            irq_is(1'b0);
            wr(8'h14, {16'h0000, pos});
            idle();
        end
        wr(8'h18, 32'h0000_0004);
        fork
            rd(8'h14, 32'h0000_0004);
            usb_engine_model_inst.sof(1'b1, 11'h001);
        join
        irq_is(1'b1);
        wr(8'h1c, 32'h0000_0004);
        idle();
        irq_is(1'b0);
        // a flag raised in the cycle of its own clear must survive
        fork
            wr(8'h1c, 32'h0000_0004);
            usb_engine_model_inst.sof(1'b1, 11'h002);
        join
        fork
            rd(8'h1c, 32'h0000_0004);
            usb_engine_model_inst.msof(1'b1, 3'h3);
        join
        // sof and msof together: sof decides the error bit and clears the micro index
        fork
            usb_engine_model_inst.sof(1'b1, 11'h005);
            usb_engine_model_inst.msof(1'b0, 3'h6);
        join
        rd(8'h10, 32'h0000_0028);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(8'h18, '0);
        rd(8'h10, '0);
        final_report();
    end
endmodule
